// ### verification/spf_modem.sv
`timescale 1ns/1ps

module spf_modem #(
	parameter int BIT = 174
) (
	input wire logic clock_i,
	input wire logic txd_i,
	input wire logic [3:0] nbits_i,
	output logic rxd_o,
	output logic [10:0] word_o,
	output logic got_o,
	output int gap_o
);
	int since;
	logic [10:0] w;
	// Loopback plug: the transmit pin feeds the receive pin.
	assign rxd_o = txd_i;
	// Samples each bit centre after a start edge and times start to start.
	initial begin
		got_o = 1'b0;
		word_o = 11'h000;
		gap_o = 0;
		since = 1000000;
		forever begin
			@(negedge clock_i);
			got_o <= 1'b0;
			since++;
			if (txd_i === 1'b0) begin
				gap_o <= since;
				w = 11'h000;
				repeat (BIT / 2) @(negedge clock_i);
				for (int i = 0; i < nbits_i; i++) begin
					repeat (BIT) @(negedge clock_i);
					w[i] = txd_i;
				end
				since = BIT / 2 + nbits_i * BIT;
				word_o <= w;
				got_o <= 1'b1;
			end
		end
	end
endmodule : spf_modem

// ### verification/spf_uart_asserts.sv
`timescale 1ns/1ps

module spf_uart_asserts (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic fmt_wr_i,
	input wire logic [31:0] fmt_i,
	input wire logic short_wr_i,
	input wire logic set_wr_i,
	input wire logic [2:0] set_i,
	input wire logic rate_wr_i,
	input wire logic rate_lit_sel_i,
	input wire logic [4:0] rate_idx_i,
	input wire logic ri_i,
	input wire logic rx_ready_i,
	input wire logic tx_ready_o,
	input wire logic [7:0] rx_data_o,
	input wire logic rx_valid_o,
	input wire logic dtr_o,
	input wire logic ring_o,
	input wire spf_pkg::spf_fmt_t fmt_o,
	input wire logic [2:0] rate_set_o,
	input wire logic [4:0] rate_idx_o,
	input wire logic rate_ok_o,
	input wire spf_pkg::spf_err_t err_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	chk_dtr_held: assert property (dtr_o)
		else $error("dtr_o low");
	chk_ring_copy: assert property (1 |=> ring_o == $past(ri_i))
		else $error("ring_o wrong");
	chk_set_refused: assert property (set_wr_i && set_i > 3'h5 |=>
		err_o.rate && $stable(rate_set_o)) else $error("bad set taken");
	chk_set_taken: assert property (set_wr_i && set_i <= 3'h5 |=>
		rate_set_o == $past(set_i)) else $error("set not taken");
	chk_idx_range: assert property (rate_wr_i && !rate_lit_sel_i && rate_idx_i > 5'h1C
		|=> err_o.rate && $stable(rate_idx_o)) else $error("bad index taken");
	chk_fmt_load: assert property (fmt_wr_i |=> fmt_o == $past(fmt_i[5:0]))
		else $error("fmt_o not loaded");
	chk_fmt_hold: assert property (!fmt_wr_i && !short_wr_i |=> $stable(fmt_o))
		else $error("fmt_o moved");
	chk_top_rate: assert property (rate_ok_o |->
		$past(rate_idx_o) != 5'h13 || $past(rate_set_o) == 3'h2) else $error("rate 19 ok");
	chk_rx_held: assert property (rx_valid_o && !rx_ready_i |=>
		rx_valid_o && $stable(rx_data_o)) else $error("rx not held");
	chk_rx_upper: assert property (rx_valid_o && fmt_o.len != spf_pkg::SPF_LEN8
		|-> !rx_data_o[7]) else $error("rx upper bit set");
	cover property (err_o.rate);
	cover property (!tx_ready_o);
	cover property (rx_valid_o && rx_ready_i);
endmodule : spf_uart_asserts

bind spf_uart spf_uart_asserts u_chk (.clock_i, .rstn_i, .fmt_wr_i, .fmt_i, .short_wr_i,
	.set_wr_i, .set_i, .rate_wr_i, .rate_lit_sel_i, .rate_idx_i, .ri_i, .rx_ready_i,
	.tx_ready_o, .rx_data_o, .rx_valid_o, .dtr_o, .ring_o, .fmt_o, .rate_set_o,
	.rate_idx_o, .rate_ok_o, .err_o);

// ### verification/testbench.sv
`timescale 1ns/1ps

module testbench;
	typedef struct {logic [10:0] w; int h;} spf_exp_t;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic fmt_wr_i = 1'b0, short_wr_i = 1'b0, set_wr_i = 1'b0, rate_wr_i = 1'b0;
	logic rate_lit_sel_i = 1'b0, tx_valid_i = 1'b0, rx_ready_i = 1'b0;
	logic dcd_i = 1'b1, dsr_i = 1'b1, cts_i = 1'b1, ri_i = 1'b0, r;
	logic [31:0] fmt_i = 32'h0;
	logic [2:0] short_code_i = 3'h0, set_i = 3'h0;
	logic [4:0] rate_idx_i = 5'h0;
	logic [17:0] rate_lit_i = 18'h0;
	logic [7:0] tx_data_i = 8'h0, rx_data_o;
	logic rxd_i, tx_ready_o, rx_valid_o, txd_o, dtr_o, rts_o, ring_o, rate_ok_o, got_o;
	spf_pkg::spf_fmt_t fmt_o;
	spf_pkg::spf_err_t err_o;
	logic [2:0] rate_set_o;
	logic [4:0] rate_idx_o;
	logic [10:0] wword;
	logic [5:0] f = 6'h00;
	logic [5:0] fm [6] = '{6'h00, 6'h1D, 6'h07, 6'h0C, 6'h2A, 6'h3B};
	logic [3:0] nbits;
	int gap, failures = 0, check_count = 0, junk;
	spf_exp_t wq[$], e;
	logic [7:0] rq[$];
	assign nbits = 4'h9 - {2'b00, f[1:0]} + {3'b000, f[3]};
	spf_uart u_dut (.clock_i, .rstn_i, .fmt_wr_i, .fmt_i, .short_wr_i, .short_code_i,
		.set_wr_i, .set_i, .rate_wr_i, .rate_lit_sel_i, .rate_idx_i, .rate_lit_i,
		.tx_data_i, .tx_valid_i, .tx_ready_o, .rx_data_o, .rx_valid_o, .rx_ready_i,
		.dcd_i, .rxd_i, .dsr_i, .cts_i, .ri_i, .txd_o, .dtr_o, .rts_o, .ring_o, .fmt_o,
		.rate_set_o, .rate_idx_o, .rate_ok_o, .err_o);
	spf_modem #(.BIT(174)) u_modem (.clock_i, .txd_i(txd_o), .nbits_i(nbits),
		.rxd_o(rxd_i), .word_o(wword), .got_o, .gap_o(gap));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial forever #12.5 clock_i = ~clock_i;
	task cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : cyc
	task chk(input string s, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (x !== g) begin
			$display("MISMATCH %s expected %0h seen %0h", s, x, g);
			failures++;
		end
	endtask : chk
	task end_of_test();
		if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task cfg(input int k, input logic [17:0] v);
		fmt_i = {26'h0000000, v[5:0]};
		{fmt_wr_i, short_wr_i, set_wr_i} = {k == 0, k == 1, k == 2};
		{rate_wr_i, rate_lit_sel_i} = {k >= 3, k == 4};
		{short_code_i, set_i, rate_idx_i, rate_lit_i} = {v[2:0], v[2:0], v[4:0], v};
		cyc(1);
		{fmt_wr_i, short_wr_i, set_wr_i, rate_wr_i} = 4'h0;
		cyc(1);
	endtask : cfg
	function automatic logic [5:0] short_exp(input int c);
		return {1'b0, c == 0 || c == 2 || c == 6, !(c == 4 || c == 5),
			c == 0 || c == 1 || c == 4, 1'b0, c < 4};
	endfunction : short_exp
	task send(input logic [7:0] d);
		logic [7:0] m;
		logic p;
		int nb, n;
		nb = 8 - f[1:0];
		m = d & (8'hFF >> f[1:0]);
		p = f[5] ? ~f[4] : (f[4] ? ^m : ~^m);
		e.w = 11'(m) | (11'(f[3] & p) << nb) | (11'h001 << (nb + f[3]));
		e.h = 2 * (1 + nb + f[3]) + (!f[2] ? 2 : (nb == 8 && f[3]) ? 2 : (nb == 5 && !f[3]) ? 3 : 4);
		wq.push_back(e);
		if (dcd_i) rq.push_back(m);
		tx_data_i = d;
		tx_valid_i = 1'b1;
		n = 0;
		while (tx_ready_o !== 1'b1 && n < 30000) begin
			cyc(1);
			n++;
		end
		if (n >= 30000) chk("tx_wait", 0, n);
		cyc(1);
	endtask : send
	task drain();
		int n;
		tx_valid_i = 1'b0;
		n = 0;
		while (wq.size() + rq.size() != 0 && n < 30000) begin
			cyc(1);
			n++;
		end
		chk("queues", 0, wq.size() + rq.size());
		cyc(2200);
	endtask : drain
	// ----------------------------------------------------------------
	// Monitors
	// ----------------------------------------------------------------
	always @(posedge clock_i) begin
		if (got_o === 1'b1) begin
			if (wq.size() == 0) chk("wire_extra", 1, 0);
			else begin
				e = wq.pop_front();
				chk("txd_frame", e.w, wword);
				if (gap < 2500) chk("halfbits", e.h, (gap * 1152 + 50000) / 100000);
			end
		end
	end
	always @(negedge clock_i) begin
		r = 1'($urandom);
		ri_i <= 1'($urandom);
		if (rx_valid_o === 1'b1) chk("rts_o", 0, rts_o);
		if (rx_valid_o === 1'b1 && r) begin
			if (rq.size() == 0) chk("rx_extra", 1, 0);
			else chk("rx_data_o", rq.pop_front(), rx_data_o);
		end
		rx_ready_i <= r;
	end
	initial begin
		#(100000 * 25);
		failures++;
		end_of_test();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		junk = $urandom(32'hBE09);
		cyc(4);
		rstn_i = 1'b1;
		chk("fmt_o", 0, fmt_o);
		chk("rate_set_o", 4, rate_set_o);
		chk("rate_idx_o", 0, rate_idx_o);
		chk("dtr_o", 1, dtr_o);
		for (int c = 0; c < 8; c++) begin
			cfg(1, c);
			chk("fmt_o", short_exp(c), fmt_o);
		end
		for (int i = 0; i < 8; i++) begin
			f = 6'($urandom);
			cfg(0, f);
			chk("fmt_o", f, fmt_o);
		end
		cfg(2, 6);
		chk("rate_set_o", 4, rate_set_o);
		cfg(3, 19);
		chk("rate_idx_o", 0, rate_idx_o);
		cfg(3, 18);
		chk("rate_ok_o", 1, rate_ok_o);
		cfg(2, 2);
		cfg(4, 18'h1C200);
		chk("rate_idx_o", 18, rate_idx_o);
		cfg(4, 18'h38400);
		chk("rate_idx_o", 19, rate_idx_o);
		cfg(3, 29);
		chk("rate_idx_o", 19, rate_idx_o);
		chk("rate_ok_o", 1, rate_ok_o);
		for (int k = 0; k < 6; k++) begin
			f = fm[k];
			cfg(0, f);
			for (int i = 0; i < 3; i++) send(8'($urandom));
			drain();
		end
		cts_i = 1'b0;
		for (int i = 0; i < 4; i++) send(8'($urandom));
		tx_valid_i = 1'b0;
		cyc(2);
		chk("tx_ready_o", 0, tx_ready_o);
		{cts_i, dsr_i} = 2'b10;
		cyc(400);
		chk("tx_ready_o", 0, tx_ready_o);
		dsr_i = 1'b1;
		send(8'($urandom));
		drain();
		dcd_i = 1'b0;
		send(8'h5A);
		drain();
		dcd_i = 1'b1;
		end_of_test();
	end
endmodule : testbench

// ### verilog/spf_fifo.sv
`timescale 1ns/1ps

module spf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [CW-1:0] count;

	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	wire [CW-1:0] next_count = CW'(count + CW'(push) - CW'(pop));
	wire [AW-1:0] next_wptr = (wptr == LAST_PTR) ? '0 : AW'(wptr + 1'b1);
	wire [AW-1:0] next_rptr = (rptr == LAST_PTR) ? '0 : AW'(rptr + 1'b1);

	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rptr];

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wptr] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			in_ready_o <= 1'b1;
		end else begin
			wptr <= push ? next_wptr : wptr;
			rptr <= pop ? next_rptr : rptr;
			count <= next_count;
			in_ready_o <= (next_count != FULL_COUNT);
		end
	end

endmodule : spf_fifo

// ### verilog/spf_pkg.sv
package spf_pkg;

	// ----------------------------------------------------------------
	// Clock and bit timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] OVS_MID = 4'h7;
	localparam logic [5:0] HALF_BIT_TICKS = 6'h08;
	localparam logic [27:0] ACC_MOD = 28'(2 * CLK_HZ);
	localparam logic [22:0] COARSE_MASK = 23'h7FFFC0;

	// ----------------------------------------------------------------
	// Framing word fields
	// ----------------------------------------------------------------
	localparam int FMT_W = 6;
	localparam int FMT_LEN_LSB = 0;
	localparam int FMT_STOP_BIT = 2;
	localparam int FMT_PAR_EN_BIT = 3;
	localparam int FMT_PTYPE_LSB = 4;
	localparam logic [5:0] FMT_RESET = 6'h00;

	typedef enum logic [1:0] {
		SPF_LEN8 = 2'b00,
		SPF_LEN7 = 2'b01,
		SPF_LEN6 = 2'b10,
		SPF_LEN5 = 2'b11
	} spf_len_t;

	typedef enum logic [1:0] {
		SPF_PAR_ODD = 2'b00,
		SPF_PAR_EVEN = 2'b01,
		SPF_PAR_MARK = 2'b10,
		SPF_PAR_SPACE = 2'b11
	} spf_ptype_t;

	typedef struct packed {
		spf_ptype_t ptype;
		logic par_en;
		logic two_stop;
		spf_len_t len;
	} spf_fmt_t;

	typedef struct packed {
		logic parity;
		logic frame;
		logic overrun;
		logic rate;
	} spf_err_t;

	typedef enum logic [2:0] {
		SPF_IDLE = 3'b000,
		SPF_START = 3'b001,
		SPF_DATA = 3'b010,
		SPF_PAR = 3'b011,
		SPF_STOP = 3'b100
	} spf_state_t;

	// Shorthand codes 7..0 expanded to framing words, code 0 rightmost.
	localparam logic [7:0][5:0] SHORT_FMT = {6'h08, 6'h18, 6'h00, 6'h04,
		6'h09, 6'h19, 6'h0D, 6'h1D};

	// ----------------------------------------------------------------
	// Rate sets
	// ----------------------------------------------------------------
	localparam int NUM_IDX = 29;
	localparam logic [4:0] MAX_IDX = 5'h1C;
	localparam logic [2:0] MAX_SET = 3'h5;
	localparam logic [2:0] DEFAULT_SET = 3'h4;
	localparam logic [2:0] SET_ALT0 = 3'h2;
	localparam logic [2:0] SET_ALT1 = 3'h3;

	// Entries present per set, set 5 leftmost.
	localparam logic [5:0][28:0] AVAIL = {29'h1FF6FFFF, 29'h1FE7FFFF, 29'h1FF6FE7F,
		29'h1FF8FE7F, 29'h1FC0FFFF, 29'h1FC1FEFF};
	// Entries taken from the standard rate table per set.
	localparam logic [5:0][28:0] STAR = {29'h013681C1, 29'h0D2701C1, 29'h12B6E401,
		29'h0478EE01, 29'h10003DFF, 29'h00011EF9};

	// Returns twice the rate in bit/s, so the half rate stays whole.
	function automatic logic [18:0] spf_rate2(input logic [2:0] set, input logic [4:0] idx);
		logic [18:0] r;
		r = 19'h00000;
		case (idx)
			5'h00: r = (set == SET_ALT0 || set == SET_ALT1) ? 19'h03840 : 19'h04B00;
			5'h01: r = 19'h00096;
			5'h02: r = 19'h0012C;
			5'h03: r = 19'h00258;
			5'h04: r = 19'h00960;
			5'h05: r = 19'h012C0;
			5'h06: r = 19'h02580;
			5'h07: r = 19'h04B00;
			5'h08: r = 19'h09600;
			5'h09: r = 19'h00064;
			5'h0A: r = 19'h000DC;
			5'h0B: r = 19'h0010D;
			5'h0C: r = 19'h004B0;
			5'h0D: r = 19'h00E10;
			5'h0E: r = 19'h01C20;
			5'h0F: r = 19'h03840;
			5'h10: r = 19'h12C00;
			5'h11: r = 19'h1C200;
			5'h12: r = 19'h38400;
			5'h13: r = 19'h70800;
			5'h14: r = 19'h07080;
			5'h15: r = 19'h0E100;
			5'h16: r = 19'h00190;
			5'h17: r = 19'h00384;
			5'h18: r = 19'h006E0;
			5'h19: r = 19'h00708;
			5'h1A: r = 19'h00834;
			5'h1B: r = 19'h00868;
			5'h1C: r = 19'h00FA0;
			default: r = 19'h00000;
		endcase
		return r;
	endfunction : spf_rate2

endpackage : spf_pkg

// ### verilog/spf_uart.sv
`timescale 1ns/1ps

// Overview of operation
// - Bits 1:0 pick 8, 7, 6 or 5 data bits and bit 2 gives two stop bits, one for 8 bits with parity and one and a half for 5 bits without.
// - Bit 3 enables parity and bits 5:4 choose odd, even, forced one or forced zero, the forced kinds being ignored on receive.
// - A shorthand code 0 to 7 selects 7-bit even or odd framing with two then one stop bits, or 8-bit no-parity two or one stop bits then even or odd with one.
// - A rate index is mapped through one of six rate sets, set four being used after reset.
// - Set four covers 50 to 115200 bit/s and only set two offers 230400 bit/s.
// - Starred rates come exactly from the standard table while the rest come from a timer that is finer on odd ports than on even ports.
// - One rate selection sets both directions and takes an index 0 to 28 or a literal rate 50 to 230400 bit/s.
// - Terminal ready is held high, a character is sent only with clear-to-send and data-set-ready high, and one is received only with carrier detect high.
module spf_uart #(
	parameter logic [4:0] DEFAULT_INDEX = 5'h00,
	parameter bit ODD_PORT = 1'b1,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic fmt_wr_i,
	input wire logic [31:0] fmt_i,
	input wire logic short_wr_i,
	input wire logic [2:0] short_code_i,
	input wire logic set_wr_i,
	input wire logic [2:0] set_i,
	input wire logic rate_wr_i,
	input wire logic rate_lit_sel_i,
	input wire logic [4:0] rate_idx_i,
	input wire logic [17:0] rate_lit_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	input wire logic dcd_i,
	input wire logic rxd_i,
	input wire logic dsr_i,
	input wire logic cts_i,
	input wire logic ri_i,
	output logic txd_o,
	output logic dtr_o,
	output logic rts_o,
	output logic ring_o,
	output spf_pkg::spf_fmt_t fmt_o,
	output logic [2:0] rate_set_o,
	output logic [4:0] rate_idx_o,
	output logic rate_ok_o,
	output spf_pkg::spf_err_t err_o
);

	// ----------------------------------------------------------------
	// Framing selection
	// ----------------------------------------------------------------
	wire [5:0] short_word = spf_pkg::SHORT_FMT[short_code_i];
	wire [5:0] fmt_word = fmt_i[spf_pkg::FMT_W-1:0];
	wire [5:0] next_fmt = fmt_wr_i ? fmt_word : (short_wr_i ? short_word : fmt_o);
	wire spf_pkg::spf_len_t len = fmt_o.len;
	wire [3:0] nbits = 4'(4'h8 - {2'b00, len});
	wire is8 = (len == spf_pkg::SPF_LEN8);
	wire is5 = (len == spf_pkg::SPF_LEN5);
	wire [1:0] stop_half = !fmt_o.two_stop ? 2'h2 :
		((is8 && fmt_o.par_en) ? 2'h2 : ((is5 && !fmt_o.par_en) ? 2'h3 : 2'h0));
	wire [5:0] stop_ticks = (stop_half == 2'h0) ? 6'h20 :
		6'(stop_half * spf_pkg::HALF_BIT_TICKS);
	wire [7:0] data_mask = 8'(8'hFF >> (4'h8 - nbits));

	// ----------------------------------------------------------------
	// Rate selection
	// ----------------------------------------------------------------
	localparam int NUM_IDX_W = spf_pkg::NUM_IDX;
	logic [2:0] rate_set;
	logic [4:0] rate_idx;
	logic [26:0] acc;
	logic [NUM_IDX_W-1:0] lit_match;
	logic [4:0] lit_idx;
	logic lit_found;

	for (genvar g = 0; g < spf_pkg::NUM_IDX; g++) begin : g_lit
		assign lit_match[g] = spf_pkg::AVAIL[rate_set][g] &&
			(spf_pkg::spf_rate2(rate_set, 5'(g)) == {rate_lit_i, 1'b0});
	end

	always_comb begin
		lit_idx = 5'h00;
		lit_found = 1'b0;
		for (int i = spf_pkg::NUM_IDX - 1; i >= 0; i--) begin
			if (lit_match[i]) begin
				lit_idx = 5'(i);
				lit_found = 1'b1;
			end
		end
	end

	wire [4:0] req_idx = rate_lit_sel_i ? lit_idx : rate_idx_i;
	wire req_idx_ok = (req_idx <= spf_pkg::MAX_IDX) && spf_pkg::AVAIL[rate_set][req_idx];
	wire rate_req_ok = rate_lit_sel_i ? lit_found : req_idx_ok;
	wire set_ok = (set_i <= spf_pkg::MAX_SET);
	wire [2:0] next_rate_set = (set_wr_i && set_ok) ? set_i : rate_set;
	wire [4:0] next_rate_idx = (rate_wr_i && rate_req_ok) ? req_idx : rate_idx;
	wire next_rate_err = (set_wr_i && !set_ok) || (rate_wr_i && !rate_req_ok);
	wire cur_ok = (rate_idx <= spf_pkg::MAX_IDX) && spf_pkg::AVAIL[rate_set][rate_idx];
	wire cur_star = spf_pkg::STAR[rate_set][rate_idx];
	wire [22:0] inc_exact = {spf_pkg::spf_rate2(rate_set, rate_idx), 4'h0};
	wire use_coarse = !cur_star && !ODD_PORT;
	wire [22:0] inc = use_coarse ? (inc_exact & spf_pkg::COARSE_MASK) : inc_exact;
	wire [27:0] acc_sum = {1'b0, acc} + {5'h00, inc};
	wire tick = rate_ok_o && (acc_sum >= spf_pkg::ACC_MOD);
	wire [26:0] next_acc = !rate_ok_o ? 27'h0000000 :
		(tick ? 27'(acc_sum - spf_pkg::ACC_MOD) : acc_sum[26:0]);

	// ----------------------------------------------------------------
	// Transmit path
	// ----------------------------------------------------------------
	logic [7:0] fifo_data;
	logic fifo_valid;
	spf_pkg::spf_state_t tx_state;
	logic [5:0] tx_tcnt;
	logic [3:0] tx_bit;
	logic [7:0] tx_sh;
	logic tx_par;

	wire tx_allowed = cts_i && dsr_i && rate_ok_o;
	wire tx_load = (tx_state == spf_pkg::SPF_IDLE) && fifo_valid && tx_allowed;
	wire [7:0] load_data = fifo_data & data_mask;
	wire load_par = (fmt_o.ptype == spf_pkg::SPF_PAR_ODD) ? ~^load_data :
		((fmt_o.ptype == spf_pkg::SPF_PAR_EVEN) ? ^load_data :
		(fmt_o.ptype == spf_pkg::SPF_PAR_MARK));
	wire tx_bit_end = tick && (tx_tcnt[3:0] == spf_pkg::OVS_LAST);
	wire tx_stop_end = tick && (tx_tcnt == 6'(stop_ticks - 6'h01));
	wire tx_last_data = (tx_bit == 4'(nbits - 4'h1));
	spf_pkg::spf_state_t next_tx_state;

	always_comb begin
		next_tx_state = tx_state;
		case (tx_state)
			spf_pkg::SPF_IDLE: begin
				if (tx_load) begin
					next_tx_state = spf_pkg::SPF_START;
				end
			end
			spf_pkg::SPF_START: begin
				if (tx_bit_end) begin
					next_tx_state = spf_pkg::SPF_DATA;
				end
			end
			spf_pkg::SPF_DATA: begin
				if (tx_bit_end && tx_last_data) begin
					next_tx_state = fmt_o.par_en ? spf_pkg::SPF_PAR : spf_pkg::SPF_STOP;
				end
			end
			spf_pkg::SPF_PAR: begin
				if (tx_bit_end) begin
					next_tx_state = spf_pkg::SPF_STOP;
				end
			end
			spf_pkg::SPF_STOP: begin
				if (tx_stop_end) begin
					next_tx_state = spf_pkg::SPF_IDLE;
				end
			end
			default: next_tx_state = spf_pkg::SPF_IDLE;
		endcase
	end

	wire tx_state_chg = (next_tx_state != tx_state);
	wire [5:0] next_tx_tcnt = (tx_state_chg || tx_bit_end && tx_state == spf_pkg::SPF_DATA) ?
		6'h00 : (tick ? 6'(tx_tcnt + 6'h01) : tx_tcnt);
	wire tx_shift = tx_bit_end && (tx_state == spf_pkg::SPF_DATA);
	wire [7:0] next_tx_sh = tx_load ? load_data : (tx_shift ? {1'b0, tx_sh[7:1]} : tx_sh);
	wire [3:0] next_tx_bit = tx_load ? 4'h0 : (tx_shift ? 4'(tx_bit + 4'h1) : tx_bit);
	wire next_txd = (next_tx_state == spf_pkg::SPF_START) ? 1'b0 :
		((next_tx_state == spf_pkg::SPF_DATA) ? next_tx_sh[0] :
		((next_tx_state == spf_pkg::SPF_PAR) ? tx_par : 1'b1));

	spf_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.in_data_i(tx_data_i),
		.in_valid_i(tx_valid_i),
		.in_ready_o(tx_ready_o),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(tx_load)
	);

	// ----------------------------------------------------------------
	// Receive path
	// ----------------------------------------------------------------
	spf_pkg::spf_state_t rx_state;
	logic [3:0] rx_tcnt;
	logic [3:0] rx_bit;
	logic [7:0] rx_sh;
	logic rx_par_bad;

	wire rx_mid = tick && (rx_tcnt == spf_pkg::OVS_MID);
	wire rx_end = tick && (rx_tcnt == spf_pkg::OVS_LAST);
	wire [7:0] rx_word = 8'(rx_sh >> (4'h8 - nbits));
	wire rx_exp_par = (fmt_o.ptype == spf_pkg::SPF_PAR_ODD) ? ~^rx_word : ^rx_word;
	wire par_checked = fmt_o.ptype == spf_pkg::SPF_PAR_ODD ||
		fmt_o.ptype == spf_pkg::SPF_PAR_EVEN;
	wire rx_last_data = (rx_bit == 4'(nbits - 4'h1));
	wire rx_done = rx_end && (rx_state == spf_pkg::SPF_STOP);
	wire rx_take = rx_done && dcd_i && (!rx_valid_o || rx_ready_i);
	wire rx_lost = rx_done && dcd_i && rx_valid_o && !rx_ready_i;
	spf_pkg::spf_state_t next_rx_state;

	always_comb begin
		next_rx_state = rx_state;
		case (rx_state)
			spf_pkg::SPF_IDLE: begin
				if (dcd_i && !rxd_i && rate_ok_o) begin
					next_rx_state = spf_pkg::SPF_START;
				end
			end
			spf_pkg::SPF_START: begin
				if (rx_mid) begin
					next_rx_state = rxd_i ? spf_pkg::SPF_IDLE : spf_pkg::SPF_DATA;
				end
			end
			spf_pkg::SPF_DATA: begin
				if (rx_end && rx_last_data) begin
					next_rx_state = fmt_o.par_en ? spf_pkg::SPF_PAR : spf_pkg::SPF_STOP;
				end
			end
			spf_pkg::SPF_PAR: begin
				if (rx_end) begin
					next_rx_state = spf_pkg::SPF_STOP;
				end
			end
			spf_pkg::SPF_STOP: begin
				if (rx_end) begin
					next_rx_state = spf_pkg::SPF_IDLE;
				end
			end
			default: next_rx_state = spf_pkg::SPF_IDLE;
		endcase
	end

	wire rx_restart = (rx_state == spf_pkg::SPF_START) && rx_mid;
	wire [3:0] next_rx_tcnt = (rx_state == spf_pkg::SPF_IDLE || rx_restart) ? 4'h0 :
		(tick ? 4'(rx_tcnt + 4'h1) : rx_tcnt);
	wire rx_sample = rx_end && (rx_state == spf_pkg::SPF_DATA);
	wire [7:0] next_rx_sh = rx_restart ? 8'h00 : (rx_sample ? {rxd_i, rx_sh[7:1]} : rx_sh);
	wire [3:0] next_rx_bit = rx_restart ? 4'h0 : (rx_sample ? 4'(rx_bit + 4'h1) : rx_bit);
	wire next_par_bad = rx_restart ? 1'b0 :
		((rx_end && rx_state == spf_pkg::SPF_PAR) ? (par_checked && rxd_i != rx_exp_par) :
		rx_par_bad);
	wire next_rx_valid = rx_take ? 1'b1 : (rx_ready_i ? 1'b0 : rx_valid_o);
	wire [7:0] next_rx_data = rx_take ? rx_word : rx_data_o;
	wire spf_pkg::spf_err_t next_err = '{parity: rx_take && rx_par_bad,
		frame: rx_take && !rxd_i, overrun: rx_lost, rate: next_rate_err};

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fmt_o <= spf_pkg::FMT_RESET;
			rate_set <= spf_pkg::DEFAULT_SET;
			rate_idx <= DEFAULT_INDEX;
			rate_ok_o <= 1'b0;
			acc <= '0;
			err_o <= '0;
		end else begin
			fmt_o <= next_fmt;
			rate_set <= next_rate_set;
			rate_idx <= next_rate_idx;
			rate_ok_o <= cur_ok;
			acc <= next_acc;
			err_o <= next_err;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_state <= spf_pkg::SPF_IDLE;
			tx_tcnt <= 6'h00;
			tx_bit <= 4'h0;
			tx_sh <= 8'h00;
			tx_par <= 1'b0;
			txd_o <= 1'b1;
		end else begin
			tx_state <= next_tx_state;
			tx_tcnt <= next_tx_tcnt;
			tx_bit <= next_tx_bit;
			tx_sh <= next_tx_sh;
			tx_par <= tx_load ? load_par : tx_par;
			txd_o <= next_txd;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_state <= spf_pkg::SPF_IDLE;
			rx_tcnt <= 4'h0;
			rx_bit <= 4'h0;
			rx_sh <= 8'h00;
			rx_par_bad <= 1'b0;
			rx_valid_o <= 1'b0;
			rx_data_o <= 8'h00;
		end else begin
			rx_state <= next_rx_state;
			rx_tcnt <= next_rx_tcnt;
			rx_bit <= next_rx_bit;
			rx_sh <= next_rx_sh;
			rx_par_bad <= next_par_bad;
			rx_valid_o <= next_rx_valid;
			rx_data_o <= next_rx_data;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dtr_o <= 1'b1;
			rts_o <= 1'b0;
			ring_o <= 1'b0;
		end else begin
			dtr_o <= 1'b1;
			rts_o <= !next_rx_valid;
			ring_o <= ri_i;
		end
	end

	assign rate_set_o = rate_set;
	assign rate_idx_o = rate_idx;

endmodule : spf_uart
